// ### dia_cfg.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef DIA_CFG_SVH
`define DIA_CFG_SVH

// ============================================================
// Register byte offsets
`define DIA_REG_STATUS 8'h00
`define DIA_REG_VIOL 8'h04
`define DIA_REG_TRCD 8'h08
`define DIA_REG_TRC 8'h0c
`define DIA_REG_TRRD 8'h10
`define DIA_REG_TFAW 8'h14
`define DIA_REG_MR 8'h18
`define DIA_REG_EMR 8'h1c
`define DIA_REG_EMR2 8'h20
`define DIA_REG_EMR3 8'h24
`define DIA_REG_OPEN 8'h28

// ============================================================
// Address field positions
`define DIA_A_DLL_RST 8
`define DIA_A_PRE_ALL 10
`define DIA_E_DLL_DIS 0
`define DIA_E_SRF_RATE 7

// ============================================================
// Violation bit positions
`define DIA_V_RCD 0
`define DIA_V_RC 1
`define DIA_V_RRD 2
`define DIA_V_FAW 3
`define DIA_V_CLOSED 4
`define DIA_V_OPEN 5
`define DIA_V_NOTIDLE 6
`define DIA_V_RSVD 7

// ============================================================
// Timing: clock period and default minimum times
`define DIA_TCK_NS 10
`define DIA_TRCD_NS 15
`define DIA_TRC_NS 55
`define DIA_TRRD_NS 10
`define DIA_TFAW_NS 45
`define DIA_NS2CYC(ns) (((ns) + `DIA_TCK_NS - 1) / `DIA_TCK_NS)
`define DIA_DLL_LOCK_CYC 200
`define DIA_AGE_MAX 8'hff

`endif

// ### dia_core.sv
// Device side command decoder, mode registers and activate timing monitor
`timescale 1ns/1ns
`include "dia_cfg.svh"
module dia_core (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire dia_pkg::dia_pins_t pins,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic ready_q,
    output logic dll_locked_q
);
    import dia_pkg::*;

    // ============================================================
    // Helpers
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == `DIA_AGE_MAX) ? v : v + 8'h01;
    endfunction : sat_inc

    function automatic dia_cmd_t decode(input dia_pins_t p);
        // Low CKE or deselect is treated as no operation
        if (!p.cke || p.cs_n) begin
            decode = DIA_NOP;
        end else begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h0: decode = DIA_LM;
                3'h1: decode = DIA_REF;
                3'h2: decode = DIA_PRE;
                3'h3: decode = DIA_ACT;
                3'h4: decode = DIA_WR;
                3'h5: decode = DIA_RD;
                default: decode = DIA_NOP;
            endcase
        end
    endfunction : decode

    // ============================================================
    // Declarations
    dia_cmd_t cmd; // Command this cycle
    logic [13:0] mr_q, emr_q, emr2_q, emr3_q; // Mode registers
    dia_dll_t dll_q; // DLL lock state
    logic [7:0] lock_cnt_q; // Cycles since DLL reset
    logic [7:0] open_q; // One bit per open bank
    logic [7:0] bank_age_q [8]; // Cycles since bank activate
    logic [7:0] any_age_q; // Cycles since any activate
    logic [7:0] faw_age_q [4]; // Ages of last four activates
    logic [7:0] trcd_q, trc_q, trrd_q, tfaw_q; // Programmed counts
    logic [7:0] viol_q; // Sticky violation flags
    logic [7:0] viol_set; // Violations seen this cycle
    logic [7:0] viol_clr; // Software clear mask
    logic [2:0] b; // Addressed bank
    logic take; // Bus access accepted this edge

    assign cmd = decode(pins);
    assign b = pins.ba;
    assign take = !avs_waitrequest && (avs_read || avs_write);
    assign viol_clr = (take && avs_write && avs_address == `DIA_REG_VIOL)
                      ? avs_writedata[7:0] : 8'h00;

    // ============================================================
    // Mode register loads
    // Bank decode selects register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mr_q <= 14'h0000;
            emr_q <= 14'h0000;
            emr2_q <= 14'h0000;
            emr3_q <= 14'h0000;
        end else if (cmd == DIA_LM) begin
            case (b[1:0])
                2'h0: mr_q <= pins.addr;
                2'h1: emr_q <= pins.addr;
                2'h2: emr2_q <= pins.addr;
                default: emr3_q <= pins.addr;
            endcase
        end
    end

    // ============================================================
    // DLL lock tracking; a new DLL reset restarts the count
    // Lock 200 cycles after reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dll_q <= DIA_DLL_OFF;
            lock_cnt_q <= 8'h00;
        end else if (cmd == DIA_LM && b[1:0] == 2'h0
                     && pins.addr[`DIA_A_DLL_RST]) begin
            dll_q <= DIA_DLL_LOCKING;
            lock_cnt_q <= 8'h01;
        end else begin
            case (dll_q)
                DIA_DLL_LOCKING: begin
                    // Low CKE stalls the count: the DLL needs clock input
                    if (pins.cke) begin
                        lock_cnt_q <= sat_inc(lock_cnt_q);
                    end
                    if (lock_cnt_q == 8'(`DIA_DLL_LOCK_CYC)) begin
                        dll_q <= DIA_DLL_LOCKED;
                    end
                end
                DIA_DLL_LOCKED: begin
                    // Disabling the DLL loses the lock
                    if (emr_q[`DIA_E_DLL_DIS]) begin
                        dll_q <= DIA_DLL_OFF;
                    end
                end
                default: dll_q <= DIA_DLL_OFF;
            endcase
        end
    end

    // ============================================================
    // Ready and lock outputs
    // Ready once the DLL has locked and MR has its DLL reset bit clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ready_q <= 1'b0;
            dll_locked_q <= 1'b0;
        end else begin
            dll_locked_q <= (dll_q == DIA_DLL_LOCKED);
            ready_q <= (dll_q == DIA_DLL_LOCKED) && !mr_q[`DIA_A_DLL_RST];
        end
    end

    // ============================================================
    // Bank open state
    // A10 closes every bank
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            open_q <= 8'h00;
        end else if (cmd == DIA_ACT) begin
            open_q[b] <= 1'b1;
        end else if (cmd == DIA_PRE) begin
            if (pins.addr[`DIA_A_PRE_ALL]) begin
                open_q <= 8'h00;
            end else begin
                open_q[b] <= 1'b0;
            end
        end
    end

    // ============================================================
    // Activate ages; counters saturate so long idle reads as "old"
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            any_age_q <= `DIA_AGE_MAX;
            for (int i = 0; i < 8; i++) begin
                bank_age_q[i] <= `DIA_AGE_MAX;
            end
            for (int i = 0; i < 4; i++) begin
                faw_age_q[i] <= `DIA_AGE_MAX;
            end
        end else begin
            any_age_q <= (cmd == DIA_ACT) ? 8'h01 : sat_inc(any_age_q);
            for (int i = 0; i < 8; i++) begin
                bank_age_q[i] <= (cmd == DIA_ACT && b == 3'(i))
                                 ? 8'h01 : sat_inc(bank_age_q[i]);
            end
            faw_age_q[0] <= (cmd == DIA_ACT) ? 8'h01 : sat_inc(faw_age_q[0]);
            for (int i = 1; i < 4; i++) begin
                faw_age_q[i] <= (cmd == DIA_ACT) ? sat_inc(faw_age_q[i-1])
                                                 : sat_inc(faw_age_q[i]);
            end
        end
    end

    // ============================================================
    // Controller-side timing and command checks, flagged for software to inspect
    always_comb begin
        viol_set = 8'h00;
        if (cmd == DIA_ACT) begin
            viol_set[`DIA_V_OPEN] = open_q[b];
            viol_set[`DIA_V_RC] = bank_age_q[b] < trc_q;
            viol_set[`DIA_V_RRD] = any_age_q < trrd_q;
            viol_set[`DIA_V_FAW] = faw_age_q[3] < tfaw_q;
        end
        if (cmd == DIA_RD || cmd == DIA_WR) begin
            viol_set[`DIA_V_CLOSED] = !open_q[b];
            viol_set[`DIA_V_RCD] = open_q[b] && bank_age_q[b] < trcd_q;
        end
        if (cmd == DIA_LM) begin
            viol_set[`DIA_V_NOTIDLE] = open_q != 8'h00;
            viol_set[`DIA_V_RSVD] = b[2]
                || (b[1:0] == 2'h3 && pins.addr != 14'h0000)
                || (b[1:0] == 2'h2 && (pins.addr
                    & ~(14'h0001 << `DIA_E_SRF_RATE)) != 14'h0000);
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            viol_q <= 8'h00;
        end else begin
            viol_q <= (viol_q & ~viol_clr) | viol_set;
        end
    end

    // ============================================================
    // Programmable timing counts
    // Counts written by software
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            trcd_q <= 8'(`DIA_NS2CYC(`DIA_TRCD_NS));
            trc_q <= 8'(`DIA_NS2CYC(`DIA_TRC_NS));
            trrd_q <= 8'(`DIA_NS2CYC(`DIA_TRRD_NS));
            tfaw_q <= 8'(`DIA_NS2CYC(`DIA_TFAW_NS));
        end else if (take && avs_write) begin
            case (avs_address)
                `DIA_REG_TRCD: trcd_q <= avs_writedata[7:0];
                `DIA_REG_TRC: trc_q <= avs_writedata[7:0];
                `DIA_REG_TRRD: trrd_q <= avs_writedata[7:0];
                `DIA_REG_TFAW: tfaw_q <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ============================================================
    // Avalon slave: one wait cycle, then waitrequest low for one edge
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (avs_waitrequest && (avs_read || avs_write)) begin
            avs_waitrequest <= 1'b0;
            case (avs_address)
                `DIA_REG_STATUS: avs_readdata <= {29'h0, !emr_q[0],
                                                  dll_locked_q, ready_q};
                `DIA_REG_VIOL: avs_readdata <= {24'h0, viol_q};
                `DIA_REG_TRCD: avs_readdata <= {24'h0, trcd_q};
                `DIA_REG_TRC: avs_readdata <= {24'h0, trc_q};
                `DIA_REG_TRRD: avs_readdata <= {24'h0, trrd_q};
                `DIA_REG_TFAW: avs_readdata <= {24'h0, tfaw_q};
                `DIA_REG_MR: avs_readdata <= {18'h0, mr_q};
                `DIA_REG_EMR: avs_readdata <= {18'h0, emr_q};
                `DIA_REG_EMR2: avs_readdata <= {18'h0, emr2_q};
                `DIA_REG_EMR3: avs_readdata <= {18'h0, emr3_q};
                `DIA_REG_OPEN: avs_readdata <= {24'h0, open_q};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ============================================================
    // Assertions
    emr3_hold_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !(cmd == DIA_LM && b[1:0] == 2'h3) |=> $stable(emr3_q))
        else $error("EMR3 changed without a load");
    emr3_load_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd == DIA_LM && b[1:0] == 2'h3)
        |=> emr3_q == $past(pins.addr))
        else $error("EMR3 load not captured");
    // Lock output must stay low while the count has only just restarted
    dll_lock_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd == DIA_LM && b[1:0] == 2'h0 && pins.addr[`DIA_A_DLL_RST])
        |-> ##2 (!dll_locked_q) [*8])
        else $error("DLL locked too early");
    ready_lock_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        ready_q |-> $past(dll_q) == DIA_DLL_LOCKED)
        else $error("Ready without DLL lock");
    pre_all_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd == DIA_PRE && pins.addr[`DIA_A_PRE_ALL]) |=> open_q == 8'h00)
        else $error("Precharge all left a bank open");
    // Read two cycles after activate, with only a NOP between
    rcd_flag_a: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        (cmd == DIA_ACT && trcd_q > 8'h02) ##1 (cmd == DIA_NOP)
        ##1 (cmd == DIA_RD && b == $past(b, 2) && trcd_q > 8'h02)
        |=> viol_q[`DIA_V_RCD])
        else $error("tRCD breach not flagged");

endmodule : dia_core

// ### dia_host_model.sv
// Behavioural DDR2 controller that drives the sequencer's command pins
`timescale 1ns/1ns
module dia_host_model (
    input wire logic ref_clk,
    output dia_pkg::dia_pins_t pins
);
    import dia_pkg::*;
    // ============================================================
    // Power-up levels
    // ODT never driven high
    initial begin
        // CKE low, ODT low, deselected, no command
        pins = {2'b00, 4'hf, 3'h0, 14'h0};
    end

    // ============================================================
    // Idle cycles
    // Only NOP between commands, CKE left at its current level
    task automatic nop(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            pins.cs_n <= 1'b1;
            {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h7;
            // Deselected lines must not keep the last address
            pins.addr <= ~pins.addr;
        end
    endtask : nop

    // CKE rises once and stays high
    task automatic cke_on();
        @(posedge ref_clk);
        pins.cke <= 1'b1;
    endtask : cke_on

    // One command for one cycle, then a NOP cycle
    task automatic cmd(input dia_cmd_t c, input logic [2:0] b,
                       input logic [13:0] a);
        @(posedge ref_clk);
        pins.cs_n <= 1'b0;
        {pins.ras_n, pins.cas_n, pins.we_n} <= c;
        pins.ba <= b;
        pins.addr <= a;
        nop(1);
    endtask : cmd
endmodule : dia_host_model

// ### dia_pkg.sv
// Types shared by the DDR2 initialization and activate sequencer
package dia_pkg;

    // ============================================================
    // Command pins sampled on each clock edge
    typedef struct packed {
        logic cke;
        logic odt;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [13:0] addr;
    } dia_pins_t;

    // Decoded command
    typedef enum logic [2:0] {
        DIA_LM, DIA_REF, DIA_PRE, DIA_ACT, DIA_WR, DIA_RD, DIA_NOP
    } dia_cmd_t;

    // DLL state
    typedef enum logic [1:0] {
        DIA_DLL_OFF, DIA_DLL_LOCKING, DIA_DLL_LOCKED
    } dia_dll_t;

endpackage : dia_pkg

// ### tb_dia_core.sv
// Self-checking bench for the DDR2 initialization and activate sequencer
`timescale 1ns/1ns
`include "dia_cfg.svh"
module tb_dia_core;
    import dia_pkg::*;
    // ============================================================
    // Signals
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ready_q;
    logic dll_locked_q;
    dia_pins_t pins;
    logic [31:0] rdata;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0;
    // Reset table: every offset, then one unmapped place
    localparam logic [7:0] RA [12] = '{8'h00, 8'h04, 8'h08, 8'h0c,
        8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h30};
    localparam logic [31:0] RV [12] = '{32'h4, 32'h0, 32'h2, 32'h6,
        32'h1, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    // ============================================================
    // Clock and cycle count
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    dia_host_model host_u (.ref_clk(ref_clk), .pins(pins));
    dia_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .pins(pins),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ready_q(ready_q), .dll_locked_q(dll_locked_q));

    // ============================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Avalon access: hold until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        // Hold until waitrequest is sampled low; a hang ends in the watchdog
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdata);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    // Check the violation flags, then clear them all
    task automatic vclr(input logic [31:0] e);
        rd("viol", `DIA_REG_VIOL, e);
        wr(`DIA_REG_VIOL, 32'hff);
    endtask : vclr

    task automatic finish_test();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // ============================================================
    // Watchdog: the run needs about 20500 cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        errors++;
        finish_test();
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 12; i++) rd("reset", RA[i], RV[i]);
        wr(`DIA_REG_MR, 32'h3fff);
        wr(8'h30, 32'hffff);
        rd("mr read only", `DIA_REG_MR, 32'h0);
        // Power-up wait of 200 us and 400 ns at 10 ns a cycle
        host_u.nop(20000);
        host_u.cke_on();
        host_u.nop(40);
        host_u.cmd(DIA_PRE, 3'h0, 14'h0400);
        host_u.cmd(DIA_LM, 3'h2, 14'h0080);
        host_u.cmd(DIA_LM, 3'h3, 14'h0000);
        host_u.cmd(DIA_LM, 3'h1, 14'h0000);
        host_u.cmd(DIA_LM, 3'h0, 14'h0100);
        t0 = cyc;
        host_u.cmd(DIA_PRE, 3'h0, 14'h0400);
        host_u.cmd(DIA_REF, 3'h0, 14'h0000);
        host_u.cmd(DIA_REF, 3'h0, 14'h0000);
        host_u.cmd(DIA_LM, 3'h0, 14'h0032);
        // Lock lands about 200 cycles after the DLL reset load
        while (cyc < t0 + 185) @(negedge ref_clk);
        chk("locked early", 32'h0, {31'h0, dll_locked_q});
        chk("ready early", 32'h0, {31'h0, ready_q});
        while (cyc < t0 + 215) @(negedge ref_clk);
        chk("locked", 32'h1, {31'h0, dll_locked_q});
        chk("ready", 32'h1, {31'h0, ready_q});
        rd("status", `DIA_REG_STATUS, 32'h7);
        rd("mr", `DIA_REG_MR, 32'h0032);
        rd("emr2", `DIA_REG_EMR2, 32'h0080);
        rd("emr3", `DIA_REG_EMR3, 32'h0);
        host_u.cmd(DIA_LM, 3'h1, 14'h0380);
        rd("emr ocd", `DIA_REG_EMR, 32'h0380);
        host_u.cmd(DIA_LM, 3'h1, 14'h0000);
        rd("emr exit", `DIA_REG_EMR, 32'h0);
        vclr(32'h0);
        host_u.cmd(DIA_LM, 3'h3, 14'h0001);
        vclr(32'h80);
        rd("emr3 kept", `DIA_REG_EMR3, 32'h1);
        // Top bank-address bit set on a mode load is reserved
        host_u.cmd(DIA_LM, 3'h6, 14'h0080);
        vclr(32'h80);
        // Column access too soon after activate, then a closed bank
        wr(`DIA_REG_TRCD, 32'h3);
        host_u.cmd(DIA_ACT, 3'h0, 14'h0010);
        host_u.cmd(DIA_RD, 3'h0, 14'h0000);
        vclr(32'h01);
        rd("open", `DIA_REG_OPEN, 32'h01);
        host_u.cmd(DIA_WR, 3'h1, 14'h0000);
        vclr(32'h10);
        // Activates to two banks closer than the bank spacing
        wr(`DIA_REG_TRRD, 32'h3);
        host_u.cmd(DIA_ACT, 3'h1, 14'h0000);
        host_u.cmd(DIA_ACT, 3'h2, 14'h0000);
        vclr(32'h04);
        // Five activates inside one window
        wr(`DIA_REG_TRRD, 32'h1);
        wr(`DIA_REG_TFAW, 32'hc);
        host_u.cmd(DIA_PRE, 3'h0, 14'h0400);
        rd("open after pre", `DIA_REG_OPEN, 32'h0);
        for (int b = 3; b < 8; b++) begin
            host_u.cmd(DIA_ACT, 3'(b), 14'h0000);
        end
        vclr(32'h08);
        rd("open five", `DIA_REG_OPEN, 32'hf8);
        host_u.cmd(DIA_ACT, 3'h3, 14'h0000);
        vclr(32'h20);
        host_u.cmd(DIA_LM, 3'h0, 14'h0032);
        vclr(32'h40);
        // Same bank reopened inside the row cycle
        host_u.cmd(DIA_PRE, 3'h0, 14'h0400);
        host_u.cmd(DIA_ACT, 3'h0, 14'h0000);
        host_u.cmd(DIA_PRE, 3'h0, 14'h0400);
        host_u.cmd(DIA_ACT, 3'h0, 14'h0000);
        vclr(32'h02);
        // Disabling the DLL drops lock and ready two edges later
        host_u.cmd(DIA_LM, 3'h1, 14'h0001);
        host_u.nop(2);
        rd("dll off", `DIA_REG_STATUS, 32'h0);
        // Reset in mid-run clears lock, mode registers and banks
        @(posedge ref_clk) resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd("status reset", `DIA_REG_STATUS, 32'h4);
        rd("open reset", `DIA_REG_OPEN, 32'h0);
        finish_test();
    end
endmodule : tb_dia_core
